//--- hdl/mac_flow_pkg.sv
// package: register map, field positions and timing constants of the flow block
package mac_flow_pkg;
    // printed offsets are word indices; byte address is four times the index
    localparam logic [7:0]  IDX_FLOW        = 8'h08;
    localparam logic [7:0]  IDX_TAG_ONE     = 8'h09;
    localparam logic [7:0]  IDX_TAG_TWO     = 8'h0a;
    localparam logic [7:0]  IDX_WAKE_LOAD   = 8'h0b;
    localparam logic [7:0]  IDX_MAC_MODE    = 8'h0d;
    localparam logic [7:0]  IDX_MAC_STATUS  = 8'h0e;
    localparam logic [9:0]  ADDR_FLOW       = {IDX_FLOW, 2'b00};
    localparam logic [9:0]  ADDR_TAG_ONE    = {IDX_TAG_ONE, 2'b00};
    localparam logic [9:0]  ADDR_TAG_TWO    = {IDX_TAG_TWO, 2'b00};
    localparam logic [9:0]  ADDR_WAKE_LOAD  = {IDX_WAKE_LOAD, 2'b00};
    localparam logic [9:0]  ADDR_MAC_MODE   = {IDX_MAC_MODE, 2'b00};
    localparam logic [9:0]  ADDR_MAC_STATUS = {IDX_MAC_STATUS, 2'b00};
    // flow register fields
    localparam int          FLOW_PT_LSB     = 16;
    localparam int          FLOW_PASS_BIT   = 2;
    localparam int          FLOW_EN_BIT     = 1;
    localparam int          FLOW_BUSY_BIT   = 0;
    // mode register fields
    localparam int          MODE_FD_BIT     = 0;
    localparam int          MODE_TXEN_BIT   = 1;
    localparam int          MODE_SPD_BIT    = 2;
    localparam int          MODE_REQ_BIT    = 3;
    localparam logic [31:0] RST_REG         = 32'h0000_0000;
    // frame layout
    localparam logic [11:0] BYTE_TYPE_HI    = 12'h00c;
    localparam logic [11:0] BYTE_TYPE_LO    = 12'h00d;
    localparam logic [11:0] BYTE_OP_LO      = 12'h00f;
    localparam logic [11:0] BYTE_PT_HI      = 12'h010;
    localparam logic [11:0] BYTE_PT_LO      = 12'h011;
    localparam logic [15:0] CTRL_TYPE       = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE    = 16'h0001;
    localparam logic [11:0] MAX_LEN_PLAIN   = 12'd1518;
    localparam logic [11:0] MAX_LEN_TAGGED  = 12'd1522;
    // timing
    localparam int          CLK_NS          = 20;
    localparam int          SLOT_BITS       = 512;
    localparam int          BIT_NS_FAST     = 10;
    localparam int          BIT_NS_SLOW     = 100;
    localparam logic [11:0] SLOT_CYC_FAST   =
        12'(SLOT_BITS * BIT_NS_FAST / CLK_NS);
    localparam logic [11:0] SLOT_CYC_SLOW   =
        12'(SLOT_BITS * BIT_NS_SLOW / CLK_NS);
    localparam int          WAKE_WORDS      = 8;
endpackage : mac_flow_pkg

//--- hdl/wake_filter_mem.sv
// wake filter word store: one write port, registered read port
`timescale 1ns/1ps
module wake_filter_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             hclk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge hclk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= mem_q[rd_addr];
    end
endmodule : wake_filter_mem

//--- hdl/pause_quanta_timer.sv
// transmit hold-off timer counting pause quanta of one slot time each
`timescale 1ns/1ps
module pause_quanta_timer #(
    parameter int QW = 16,
    parameter int CW = 12
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          load,
    input  wire logic [QW-1:0] quanta,
    input  wire logic [CW-1:0] slot_cycles,
    output logic               active
);
    logic [QW-1:0] left_q;
    logic [CW-1:0] cyc_q;
    wire           slot_end = (cyc_q == slot_cycles - CW'(1));

    // a new pause frame restarts the count, zero quanta releases at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_q <= '0;
            cyc_q  <= '0;
        end else if (load) begin
            left_q <= quanta;
            cyc_q  <= '0;
        end else if (left_q != '0) begin
            cyc_q  <= slot_end ? '0 : cyc_q + CW'(1);
            if (slot_end) begin
                left_q <= left_q - QW'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active <= 1'b0;
        end else begin
            active <= load ? (quanta != '0)
                           : (left_q > QW'(1)) || (left_q == QW'(1) && !slot_end);
        end
    end
endmodule : pause_quanta_timer

//--- hdl/mac_pause_vlan_wake_filter.sv
// receive flow control, tag detection and wake filter loading of the mac
// Contract
// - pass-control set: valid pause frame sets packet-filter status flag
// - pass-control clear: packet-filter status flag cleared
// - pause acted on only in full duplex with flow control enabled
// - all frame data forwarded; status decides keep or drop
// - promiscuous filtering outranks pass-control in packet-filter flag
// - enabled: decode pauses, hold transmitter pause time times slot
// - disabled: no control frame decoding, flow control inactive
// - half duplex: enable bit drives backpressure instead; code asserts it from the request bit, gated by enable and transmit enable
// - busy high while pause or backpressure sent; zero when done
// - tag registers compared with frame bytes 13 and 14
// - tagged frames may be 1522 bytes instead of 1518
// - after reset first wake write loads word 0, then sequential
// - pointer wraps to word 0 after eighth word
// - wake filter load register is write-only
// - half duplex: busy stays set while backpressure asserted
// - transmitted pause frames carry programmed pause time
// - no pause frames or backpressure while transmitter disabled
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module mac_pause_vlan_wake_filter
    import mac_flow_pkg::*;
#(
    parameter int DW = 32
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [9:0]    haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [DW-1:0] hwdata,
    input  wire logic          hready,
    output logic      [DW-1:0] hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          rx_valid,
    input  wire logic [7:0]    rx_data,
    input  wire logic          rx_last,
    input  wire logic          rx_error,
    input  wire logic          rx_addr_ok,
    input  wire logic          rx_promisc,
    output logic               app_valid,
    output logic      [7:0]    app_data,
    output logic               app_last,
    output logic               app_status_valid,
    output logic               app_pkt_filter,
    output logic               app_tagged,
    output logic               app_too_long,
    output logic               app_pause,
    output logic               tx_hold,
    output logic               pause_tx_req,
    output logic      [15:0]   pause_tx_time,
    input  wire logic          pause_tx_done,
    output logic               backpressure,
    input  wire logic [2:0]    wake_rd_addr,
    output logic      [31:0]   wake_rd_data
);
    // bus registers
    logic [15:0] pause_time_value_q;
    logic        pass_control_indication_q;
    logic        pause_decode_enable_q;
    logic [15:0] tag_identifier_one_q;
    logic [15:0] tag_identifier_two_q;
    logic        full_duplex_q, tx_enable_q, speed_fast_q, flow_request_q;
    logic [2:0]  wake_ptr_q;
    logic [9:0]  addr_q;
    logic        wr_phase_q;
    // receive parse state
    logic [11:0] cnt_q;
    logic [7:0]  hi_q;
    logic        ctl_type_q, pause_op_q, tagged_q;
    logic [15:0] rx_pt_q;

    // ---------------- ahb-lite slave, zero wait states ----------------
    wire         take    = hsel && htrans[1] && hready;
    wire         wr_en   = wr_phase_q;
    wire         wr_flow = wr_en && addr_q == ADDR_FLOW;
    wire         wr_t1   = wr_en && addr_q == ADDR_TAG_ONE;
    wire         wr_t2   = wr_en && addr_q == ADDR_TAG_TWO;
    wire         wr_wake = wr_en && addr_q == ADDR_WAKE_LOAD;
    wire         wr_mode = wr_en && addr_q == ADDR_MAC_MODE;
    wire         pause_busy = pause_tx_req || backpressure;
    wire [31:0]  flow_rd = {pause_time_value_q, 13'h0000,
                            pass_control_indication_q,
                            pause_decode_enable_q, pause_busy};
    wire [31:0]  mode_rd = {28'h000_0000, flow_request_q, speed_fast_q,
                            tx_enable_q, full_duplex_q};
    wire [31:0]  stat_rd = {29'h0000_0000, backpressure, pause_tx_req,
                            tx_hold};
    logic [31:0] rd_mux;

    // the wake filter slot reads as zero: its contents never leave the bus
    always_comb begin
        if (haddr == ADDR_FLOW) begin
            rd_mux = flow_rd;
        end else if (haddr == ADDR_TAG_ONE) begin
            rd_mux = {16'h0000, tag_identifier_one_q};
        end else if (haddr == ADDR_TAG_TWO) begin
            rd_mux = {16'h0000, tag_identifier_two_q};
        end else if (haddr == ADDR_MAC_MODE) begin
            rd_mux = mode_rd;
        end else if (haddr == ADDR_MAC_STATUS) begin
            rd_mux = stat_rd;
        end else begin
            rd_mux = RST_REG;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q     <= '0;
            wr_phase_q <= 1'b0;
            hrdata     <= RST_REG;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            wr_phase_q <= take && hwrite;
            if (take) begin
                addr_q <= haddr;
            end
            if (take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // busy bit position is read-only; whatever the host writes there is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pause_time_value_q        <= RST_REG[15:0];
            pass_control_indication_q <= 1'b0;
            pause_decode_enable_q     <= 1'b0;
            tag_identifier_one_q      <= RST_REG[15:0];
            tag_identifier_two_q      <= RST_REG[15:0];
            full_duplex_q             <= 1'b0;
            tx_enable_q               <= 1'b0;
            speed_fast_q              <= 1'b0;
            flow_request_q            <= 1'b0;
        end else begin
            if (wr_flow) begin
                pause_time_value_q        <= hwdata[FLOW_PT_LSB +: 16];
                pass_control_indication_q <= hwdata[FLOW_PASS_BIT];
                pause_decode_enable_q     <= hwdata[FLOW_EN_BIT];
            end
            if (wr_t1) begin
                tag_identifier_one_q <= hwdata[15:0];
            end
            if (wr_t2) begin
                tag_identifier_two_q <= hwdata[15:0];
            end
            if (wr_mode) begin
                full_duplex_q  <= hwdata[MODE_FD_BIT];
                tx_enable_q    <= hwdata[MODE_TXEN_BIT];
                speed_fast_q   <= hwdata[MODE_SPD_BIT];
                flow_request_q <= hwdata[MODE_REQ_BIT];
            end
        end
    end

    // ---------------- wake filter loading ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_ptr_q <= '0;
        end else if (wr_wake) begin
            wake_ptr_q <= wake_ptr_q + 3'd1;
        end
    end

    wake_filter_mem #(
        .WIDTH (32),
        .DEPTH (WAKE_WORDS)
    ) u_wake_mem (
        .hclk    (hclk),
        .wr_en   (wr_wake),
        .wr_addr (wake_ptr_q),
        .wr_data (hwdata),
        .rd_addr (wake_rd_addr),
        .rd_data (wake_rd_data)
    );

    // ---------------- receive parsing ----------------
    wire        at_lo   = rx_valid && cnt_q == BYTE_TYPE_LO;
    wire [15:0] word16  = {hi_q, rx_data};
    wire        tag_hit = at_lo && (word16 == tag_identifier_one_q ||
                                    word16 == tag_identifier_two_q);
    wire        decode  = pause_decode_enable_q;
    wire [11:0] len     = cnt_q + 12'd1;
    wire [11:0] max_len = tagged_q ? MAX_LEN_TAGGED : MAX_LEN_PLAIN;
    wire        rx_end  = rx_valid && rx_last;
    wire        pause_ok = rx_end && decode && ctl_type_q && pause_op_q &&
                           len > BYTE_PT_LO && !rx_error;
    wire        act_pause = pause_ok && full_duplex_q;
    // the last byte of a short frame may itself close the pause time field
    wire [15:0] pt_now = (cnt_q == BYTE_PT_LO) ? word16 : rx_pt_q;
    wire        pkt_flag  = rx_promisc ? rx_addr_ok
                          : (pass_control_indication_q && pause_ok);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q      <= '0;
            hi_q       <= '0;
            ctl_type_q <= 1'b0;
            pause_op_q <= 1'b0;
            tagged_q   <= 1'b0;
            rx_pt_q    <= '0;
        end else if (rx_valid) begin
            hi_q  <= rx_data;
            cnt_q <= rx_last ? '0 : (&cnt_q ? cnt_q : cnt_q + 12'd1);
            if (cnt_q == '0) begin
                ctl_type_q <= 1'b0;
                pause_op_q <= 1'b0;
                tagged_q   <= 1'b0;
            end
            if (at_lo) begin
                ctl_type_q <= decode && word16 == CTRL_TYPE;
                tagged_q   <= tag_hit;
            end
            if (cnt_q == BYTE_OP_LO) begin
                pause_op_q <= word16 == PAUSE_OPCODE;
            end
            if (cnt_q == BYTE_PT_LO) begin
                rx_pt_q <= word16;
            end
        end
    end

    // data leave unconditionally; drop decisions are left to the status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            app_valid        <= 1'b0;
            app_data         <= '0;
            app_last         <= 1'b0;
            app_status_valid <= 1'b0;
            app_pkt_filter   <= 1'b0;
            app_tagged       <= 1'b0;
            app_too_long     <= 1'b0;
            app_pause        <= 1'b0;
        end else begin
            app_valid        <= rx_valid;
            app_data         <= rx_data;
            app_last         <= rx_end;
            app_status_valid <= rx_end;
            if (rx_end) begin
                app_pkt_filter <= pkt_flag;
                app_tagged     <= tagged_q;
                app_too_long   <= len > max_len;
                app_pause      <= pause_ok;
            end
        end
    end

    // ---------------- transmit hold-off ----------------
    pause_quanta_timer #(
        .QW (16),
        .CW (12)
    ) u_hold (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .load        (act_pause),
        .quanta      (pt_now),
        .slot_cycles (speed_fast_q ? SLOT_CYC_FAST : SLOT_CYC_SLOW),
        .active      (tx_hold)
    );

    // ---------------- pause transmit and backpressure ----------------
    wire fd_ok  = full_duplex_q && tx_enable_q && pause_decode_enable_q;
    wire req_in = wr_mode && hwdata[MODE_REQ_BIT] && hwdata[MODE_FD_BIT] &&
                  hwdata[MODE_TXEN_BIT] && pause_decode_enable_q;

    // a new request in the cycle the frame finishes wins over the done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pause_tx_req  <= 1'b0;
            pause_tx_time <= '0;
            backpressure  <= 1'b0;
        end else begin
            if (req_in) begin
                pause_tx_req  <= 1'b1;
                pause_tx_time <= pause_time_value_q;
            end else if (pause_tx_done || !fd_ok) begin
                pause_tx_req  <= 1'b0;
            end
            backpressure <= !full_duplex_q && tx_enable_q &&
                            pause_decode_enable_q && flow_request_q;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_busy_tracks_bp: assert property (
        backpressure |-> flow_rd[FLOW_BUSY_BIT])
        else $error("busy low while backpressure asserted");
    a_busy_clears: assert property (
        pause_tx_req && pause_tx_done && !req_in && !backpressure
        |=> !flow_rd[FLOW_BUSY_BIT] || backpressure)
        else $error("busy not cleared after pause frame");
    a_no_tx_disabled: assert property (
        !tx_enable_q |=> !backpressure && (!pause_tx_req || $past(req_in)))
        else $error("flow traffic while transmitter disabled");
    a_bp_half_only: assert property (
        backpressure |-> $past(!full_duplex_q && pause_decode_enable_q))
        else $error("backpressure outside half duplex");
    a_pause_time_out: assert property (
        req_in |=> pause_tx_time == $past(pause_time_value_q))
        else $error("pause frame time differs from register");
    a_flag_cleared: assert property (
        rx_end && !pass_control_indication_q && !rx_promisc
        |=> app_status_valid && !app_pkt_filter)
        else $error("packet filter set with pass control clear");
    a_flag_set: assert property (
        pause_ok && pass_control_indication_q && !rx_promisc
        |=> app_pkt_filter)
        else $error("valid pause not flagged");
    a_hold_needs_fd: assert property (
        $rose(tx_hold) |-> $past(full_duplex_q && pause_decode_enable_q))
        else $error("hold-off outside full duplex flow control");
    a_data_forward: assert property (
        rx_valid |=> app_valid && app_data == $past(rx_data))
        else $error("received byte not forwarded");
    a_wake_wrap: assert property (
        wr_wake && wake_ptr_q == 3'd7 |=> wake_ptr_q == 3'd0)
        else $error("wake pointer did not wrap");
    a_wake_unread: assert property (
        take && !hwrite && haddr == ADDR_WAKE_LOAD |=> hrdata == RST_REG)
        else $error("wake filter readable");
    a_tag_limit: assert property (
        rx_end && tagged_q && len == MAX_LEN_TAGGED |=> !app_too_long)
        else $error("tagged frame length limit wrong");
endmodule : mac_pause_vlan_wake_filter

//--- sim/link_partner.sv
// far station model: frame source and pause send acknowledge
`timescale 1ns/1ps
module link_partner (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       pause_tx_req,
    output logic            pause_tx_done,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_last
);
    int ack_wait = 3;
    initial begin
        pause_tx_done = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
    end
    // one done pulse per request; waits for the request to drop first
    always begin
        @(posedge hclk iff (pause_tx_req === 1'b1 && hresetn));
        repeat (ack_wait) @(posedge hclk);
        pause_tx_done <= 1'b1;
        @(posedge hclk);
        pause_tx_done <= 1'b0;
        @(posedge hclk iff pause_tx_req !== 1'b1);
    end
    // bytes 12..17 carry type, opcode and pause time, big endian
    task automatic send(input int len, input logic [47:0] hdr,
                        input logic [7:0] fill);
        logic [7:0] b;
        for (int k = 0; k < len; k++) begin
            b = (k >= 12 && k < 18) ? hdr[8*(17-k) +: 8] : fill ^ 8'(k);
            rx_valid <= 1'b1;
            rx_data <= b;
            rx_last <= (k == len - 1);
            @(posedge hclk);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        // idle byte lane shows no stale value
        rx_data <= ~b;
    endtask : send
endmodule : link_partner

//--- sim/mac_pause_vlan_wake_filter_bench.sv
// self-checking bench: registers, frames, pause and wake filter
`timescale 1ns/1ps
module mac_pause_vlan_wake_filter_bench;
    import mac_flow_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [9:0]  haddr = 10'h000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, wake_rd_data, rd, seed = 32'h0001_247a;
    logic [31:0] w [8];
    logic        hreadyout, hresp, rx_valid, rx_last, rx_v1;
    logic        rx_error, rx_addr_ok, rx_promisc, pause_tx_done;
    logic        app_valid, app_last, app_status_valid, app_pkt_filter;
    logic        app_tagged, app_too_long, app_pause, tx_hold;
    logic        pause_tx_req, backpressure;
    logic [7:0]  rx_data, app_data, rx_d1;
    logic [15:0] pause_tx_time, pq;
    logic [2:0]  wake_rd_addr;
    int          failures = 0;
    int          samples_checked = 0;
    int          hc;
    int          vlen [4] = '{1522, 1523, 1518, 1519};

    always #10 hclk = ~hclk;

    mac_pause_vlan_wake_filter uut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .rx_valid, .rx_data, .rx_last, .rx_error,
        .rx_addr_ok, .rx_promisc, .app_valid, .app_data, .app_last,
        .app_status_valid, .app_pkt_filter, .app_tagged, .app_too_long,
        .app_pause, .tx_hold, .pause_tx_req, .pause_tx_time,
        .pause_tx_done, .backpressure, .wake_rd_addr, .wake_rd_data
    );
    link_partner far (.hclk, .hresetn, .pause_tx_req, .pause_tx_done,
        .rx_valid, .rx_data, .rx_last);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic check_word(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, exp);
        check_word({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask : check_bit

    // hold counts may slip one cycle either way
    task automatic check_count(input int got, exp);
        samples_checked++;
        if (got < exp - 1 || got > exp + 1) begin
            failures++;
            $display("[ERR] %0t count %0d want %0d", $time, got, exp);
        end
    endtask : check_count

    task automatic bus(input logic wr, input logic [9:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus

    task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check_word(rd, exp);
        check_bit(hresp, 1'b0);
    endtask : rdchk

    task automatic flow(input logic [15:0] pt, input logic pass, en);
        bus(1'b1, ADDR_FLOW, {pt, 13'h0000, pass, en, 1'b0});
    endtask : flow

    // sends one frame, then counts the cycles the transmitter is held
    task automatic frame(input int len, input logic [15:0] typ, pt);
        seed = lfsr(seed);
        @(posedge hclk);
        far.send(len, {typ, PAUSE_OPCODE, pt}, seed[7:0]);
        hc = 0;
        @(negedge hclk);
        while (app_status_valid !== 1'b1 && hc < 4) begin
            @(negedge hclk);
            hc++;
        end
        check_bit(app_status_valid, 1'b1);
        check_bit(app_last, 1'b1);
        hc = 0;
        while (tx_hold === 1'b1 && hc < 3000) begin
            @(negedge hclk);
            hc++;
        end
    endtask : frame

    always @(posedge hclk) begin
        rx_d1 <= rx_data;
        rx_v1 <= rx_valid & hresetn;
    end
    always @(negedge hclk) begin
        if (rx_v1) begin
            check_bit(app_valid, 1'b1);
            check_word({24'h00_0000, app_data}, {24'h00_0000, rx_d1});
        end
    end

    initial begin
        rx_error = 1'b0;
        rx_addr_ok = 1'b0;
        rx_promisc = 1'b0;
        wake_rd_addr = 3'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(ADDR_TAG_ONE, RST_REG);
        rdchk(ADDR_TAG_TWO, RST_REG);
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            w[i % 8] = seed;
            bus(1'b1, ADDR_WAKE_LOAD, seed);
        end
        rdchk(ADDR_WAKE_LOAD, RST_REG);
        for (int i = 0; i < 8; i++) begin
            @(posedge hclk);
            wake_rd_addr <= 3'(i);
            @(posedge hclk);
            @(negedge hclk);
            check_word(wake_rd_data, w[i]);
        end
        bus(1'b1, ADDR_TAG_ONE, 32'h0000_8100);
        rdchk(ADDR_TAG_ONE, 32'h0000_8100);
        for (int i = 0; i < 4; i++) begin
            frame(vlen[i], (i < 2) ? 16'h8100 : 16'h0800, 16'h0000);
            check_bit(app_tagged, i < 2);
            check_bit(app_too_long, 1'(i % 2));
        end
        bus(1'b1, ADDR_TAG_ONE, RST_REG);
        bus(1'b1, ADDR_TAG_TWO, 32'h0000_8100);
        frame(64, 16'h8100, 16'h0000);
        check_bit(app_tagged, 1'b1);
        seed = lfsr(seed);
        pq = 16'(seed % 3 + 1);
        bus(1'b1, ADDR_MAC_MODE, 32'h0000_0007);
        rdchk(ADDR_FLOW, RST_REG);
        flow(pq, 1'b1, 1'b1);
        rdchk(ADDR_FLOW, {pq, 16'h0006});
        frame(64, CTRL_TYPE, pq);
        check_bit(app_pause, 1'b1);
        check_bit(app_pkt_filter, 1'b1);
        check_count(hc, pq * SLOT_CYC_FAST);
        flow(pq, 1'b0, 1'b1);
        frame(64, CTRL_TYPE, 16'h0001);
        check_bit(app_pkt_filter, 1'b0);
        flow(pq, 1'b1, 1'b1);
        @(posedge hclk);
        rx_promisc <= 1'b1;
        frame(64, CTRL_TYPE, 16'h0001);
        check_bit(app_pkt_filter, 1'b0);
        @(posedge hclk);
        rx_promisc <= 1'b0;
        rx_error <= 1'b1;
        frame(64, CTRL_TYPE, 16'h0001);
        check_bit(app_pause, 1'b0);
        check_count(hc, 0);
        @(posedge hclk);
        rx_error <= 1'b0;
        flow(pq, 1'b1, 1'b0);
        frame(64, CTRL_TYPE, 16'h0001);
        check_bit(app_pause, 1'b0);
        check_count(hc, 0);
        bus(1'b1, ADDR_MAC_MODE, 32'h0000_0006);
        flow(pq, 1'b1, 1'b1);
        frame(64, CTRL_TYPE, 16'h0001);
        check_count(hc, 0);
        bus(1'b1, ADDR_MAC_MODE, 32'h0000_0003);
        frame(64, CTRL_TYPE, 16'h0001);
        check_count(hc, SLOT_CYC_SLOW);
        far.ack_wait = 20;
        flow(pq, 1'b0, 1'b1);
        bus(1'b1, ADDR_MAC_MODE, 32'h0000_000f);
        repeat (2) @(negedge hclk);
        check_bit(pause_tx_req, 1'b1);
        check_word({16'h0000, pause_tx_time}, {16'h0000, pq});
        rdchk(ADDR_FLOW, {pq, 16'h0003});
        rdchk(ADDR_MAC_STATUS, 32'h0000_0002);
        hc = 0;
        while (pause_tx_req !== 1'b0 && hc < 100) begin
            @(negedge hclk);
            hc++;
        end
        rdchk(ADDR_FLOW, {pq, 16'h0002});
        bus(1'b1, ADDR_MAC_MODE, 32'h0000_000e);
        repeat (2) @(negedge hclk);
        check_bit(backpressure, 1'b1);
        rdchk(ADDR_FLOW, {pq, 16'h0003});
        bus(1'b1, ADDR_MAC_MODE, 32'h0000_000c);
        repeat (2) @(negedge hclk);
        check_bit(backpressure, 1'b0);
        bus(1'b1, ADDR_MAC_MODE, 32'h0000_000d);
        repeat (2) @(negedge hclk);
        check_bit(pause_tx_req, 1'b0);
        print_verdict();
    end

    // about five times the expected run length
    initial begin
        #1_000_000;
        failures++;
        print_verdict();
    end
endmodule : mac_pause_vlan_wake_filter_bench
